// ==== fan_alarm_pkg.sv ====
package fan_alarm_pkg;

  // Register indexes, byte address is four times the index
  localparam logic [7:0] IDX_ALARM_STATUS = 8'h9B;
  localparam logic [7:0] IDX_SMI_MASK     = 8'h9C;
  localparam logic [7:0] IDX_IRQ_MASK     = 8'h9D;
  localparam logic [7:0] IDX_PWM_A_DIV    = 8'h9E;
  localparam logic [7:0] IDX_PWM_B_DIV    = 8'h9F;
  localparam logic [7:0] IDX_PWM_A_DUTY   = 8'hA0;
  localparam logic [7:0] IDX_PWM_B_DUTY   = 8'hA1;

  // Status bit positions and the divider source select bit
  localparam int BIT_TEMP_A  = 0;
  localparam int BIT_FOURTH_TACH  = 5;
  localparam int BIT_FIFTH_TACH   = 6;
  localparam int BIT_STANDBY_RAIL = 3;
  localparam int BIT_BATTERY_RAIL = 4;
  localparam int SEL_BIT     = 7;

  // Reset values and the live status bit mask
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam logic [7:0] RST_DIV    = 8'h01;
  localparam logic [7:0] RST_DUTY   = 8'hFF;
  localparam logic [6:0] LIVE_BITS  = 7'h7F;

  // Timing
  localparam longint CLK_HZ         = 125000000;
  localparam longint SRC_FAST_HZ    = 3000000;
  localparam longint SRC_SLOW_HZ    = 125000;
  localparam int     FAST_CYC       = int'(CLK_HZ / SRC_FAST_HZ);
  localparam int     SLOW_CYC       = int'(CLK_HZ / SRC_SLOW_HZ);
  localparam int     STEP_MS        = 100;
  localparam int     STEP_CYC       = int'(CLK_HZ * STEP_MS / 1000);
  localparam int     TIMEOUT_MIN    = 3;
  localparam int     TIMEOUT_STEPS  = TIMEOUT_MIN * 60 * 1000 / STEP_MS;

  // Automatic-control view of one PWM channel
  typedef struct packed {
    logic       active;
    logic [7:0] duty;
  } auto_duty_t;

  // Per-temperature-channel watch inputs
  typedef struct packed {
    logic out_of_range;
    logic fan_full;
  } temp_watch_t;

endpackage

// ==== fan_pwm_alarm.sv ====
`timescale 1ns/100ps
module fan_pwm_alarm #(
  parameter int STEP_CYCLES   = fan_alarm_pkg::STEP_CYC,
  parameter int TIMEOUT_STEPS = fan_alarm_pkg::TIMEOUT_STEPS
) (
  // Clock and reset
  input  wire logic                       SYS_CLK,
  input  wire logic                       NRST,
  // APB slave
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [11:0]                PADDR,
  input  wire logic [31:0]                PWDATA,
  output logic      [31:0]                PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  // Alarm sources
  input  wire logic                       FOURTH_TACH_LIMIT_FLAG,
  input  wire logic                       FIFTH_TACH_LIMIT_FLAG,
  input  wire logic                       BATTERY_RAIL_FLAG,
  input  wire logic                       STANDBY_RAIL_FLAG,
  input  wire fan_alarm_pkg::temp_watch_t TEMP_WATCH [3],
  // Automatic fan control view
  input  wire fan_alarm_pkg::auto_duty_t  AUTO_DUTY  [2],
  // Outputs
  output logic [1:0]                      PWM_OUT,
  output logic                            SYSTEM_MGMT_IRQ_OUT_N,
  output logic                            IRQ_OUT
);

  logic [6:0]  status_reg;
  logic [6:0]  status_next;
  logic [6:0]  status_set;
  logic [6:0]  status_clr;
  logic [6:0]  smi_mask_reg;
  logic [6:0]  irq_mask_reg;
  logic [7:0]  div_reg    [2];
  logic [7:0]  duty_reg   [2];
  logic [7:0]  duty_eff   [2];
  logic [7:0]  idx;
  logic        addr_ok;
  logic        bus_acc;
  logic        bus_wr;
  logic [7:0]  rd_val;
  logic [5:0]  fast_cnt_reg;
  logic [9:0]  slow_cnt_reg;
  logic        fast_en;
  logic        slow_en;
  logic [23:0] step_cnt_reg;
  logic        step_en;
  logic [2:0]  tmo_hit;

  // Register index decode, word aligned only
  assign idx     = PADDR[9:2];
  assign addr_ok = (PADDR[1:0] == 2'h0) && (PADDR[11:10] == 2'h0) &&
                   (idx >= fan_alarm_pkg::IDX_ALARM_STATUS) &&
                   (idx <= fan_alarm_pkg::IDX_PWM_B_DUTY);
  assign bus_acc = PSEL && PENABLE && !PREADY;
  assign bus_wr  = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;

  // Read multiplexer
  always_comb begin
    rd_val = 8'h00;
    case (idx)
      fan_alarm_pkg::IDX_ALARM_STATUS: rd_val = {1'b0, status_reg};
      fan_alarm_pkg::IDX_SMI_MASK:     rd_val = {1'b0, smi_mask_reg};
      fan_alarm_pkg::IDX_IRQ_MASK:     rd_val = {1'b0, irq_mask_reg};
      fan_alarm_pkg::IDX_PWM_A_DIV:    rd_val = div_reg[0];
      fan_alarm_pkg::IDX_PWM_B_DIV:    rd_val = div_reg[1];
      fan_alarm_pkg::IDX_PWM_A_DUTY:   rd_val = duty_eff[0];
      fan_alarm_pkg::IDX_PWM_B_DUTY:   rd_val = duty_eff[1];
      default:                         rd_val = 8'h00;
    endcase
  end

  // APB answer, one wait state
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= bus_acc;
      PSLVERR <= bus_acc && !addr_ok;
      if (bus_acc && !PWRITE && addr_ok) begin
        PRDATA <= {24'h000000, rd_val};
      end else if (bus_acc) begin
        PRDATA <= 32'h00000000;
      end
    end
  end

  // Mask registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      smi_mask_reg <= fan_alarm_pkg::RST_MASK[6:0];
      irq_mask_reg <= fan_alarm_pkg::RST_MASK[6:0];
    end else if (bus_wr) begin
      if (idx == fan_alarm_pkg::IDX_SMI_MASK) begin
        smi_mask_reg <= PWDATA[6:0];
      end
      if (idx == fan_alarm_pkg::IDX_IRQ_MASK) begin
        irq_mask_reg <= PWDATA[6:0];
      end
    end
  end

  // Divider and duty registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      div_reg[0]  <= fan_alarm_pkg::RST_DIV;
      div_reg[1]  <= fan_alarm_pkg::RST_DIV;
      duty_reg[0] <= fan_alarm_pkg::RST_DUTY;
      duty_reg[1] <= fan_alarm_pkg::RST_DUTY;
    end else if (bus_wr) begin
      case (idx)
        fan_alarm_pkg::IDX_PWM_A_DIV:  div_reg[0]  <= PWDATA[7:0];
        fan_alarm_pkg::IDX_PWM_B_DIV:  div_reg[1]  <= PWDATA[7:0];
        fan_alarm_pkg::IDX_PWM_A_DUTY: duty_reg[0] <= PWDATA[7:0];
        fan_alarm_pkg::IDX_PWM_B_DUTY: duty_reg[1] <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // Source clock enables from the system clock
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      fast_cnt_reg <= 6'h00;
      slow_cnt_reg <= 10'h000;
    end else begin
      fast_cnt_reg <= fast_en ? 6'h00 : fast_cnt_reg + 6'h01;
      slow_cnt_reg <= slow_en ? 10'h000 : slow_cnt_reg + 10'h001;
    end
  end
  assign fast_en = (fast_cnt_reg == 6'(fan_alarm_pkg::FAST_CYC - 1));
  assign slow_en = (slow_cnt_reg == 10'(fan_alarm_pkg::SLOW_CYC - 1));

  // PWM channels
  for (genvar c = 0; c < 2; c++) begin : g_pwm
    logic [6:0] pre_cnt_reg;
    logic [7:0] phase_reg;
    logic       src_en;
    logic       pre_tick;
    logic       level;

    // automatic control overrides the written duty
    assign duty_eff[c] = AUTO_DUTY[c].active ? AUTO_DUTY[c].duty : duty_reg[c];

    assign src_en = div_reg[c][fan_alarm_pkg::SEL_BIT] ? slow_en : fast_en;

    assign pre_tick = src_en && (pre_cnt_reg >= div_reg[c][6:0]);

    always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
        pre_cnt_reg <= 7'h00;
      end else if (pre_tick) begin
        pre_cnt_reg <= 7'h00;
      end else if (src_en) begin
        pre_cnt_reg <= pre_cnt_reg + 7'h01;
      end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
        phase_reg <= 8'h00;
      end else if (pre_tick) begin
        phase_reg <= phase_reg + 8'h01;
      end
    end

    // high while phase below duty, FFh held high
    assign level = (duty_eff[c] == 8'hFF) || (phase_reg < duty_eff[c]);

    always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
        PWM_OUT[c] <= 1'b1;
      end else begin
        PWM_OUT[c] <= level;
      end
    end

    AST_DUTY_ZERO_LOW: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ($past(duty_eff[c]) == 8'h00) |-> !PWM_OUT[c]) else $error("PWM high at zero duty");
    AST_DUTY_FULL_HIGH: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      ($past(duty_eff[c]) == 8'hFF) |-> PWM_OUT[c]) else $error("PWM low at full duty");
    AST_DIV_BOUND: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      src_en && !pre_tick && !bus_wr |=> pre_cnt_reg <= div_reg[c][6:0])
      else $error("Divider overrun");
  end

  // 0.1 second time base
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      step_cnt_reg <= 24'h000000;
    end else if (step_en) begin
      step_cnt_reg <= 24'h000000;
    end else begin
      step_cnt_reg <= step_cnt_reg + 24'h000001;
    end
  end
  assign step_en = (step_cnt_reg >= 24'(STEP_CYCLES - 1));

  // Target temperature timeouts
  for (genvar t = 0; t < 3; t++) begin : g_tmo
    logic [11:0] tmo_cnt_reg;
    logic        watching;

    assign watching   = TEMP_WATCH[t].out_of_range && TEMP_WATCH[t].fan_full;
    assign tmo_hit[t] = watching && step_en && (tmo_cnt_reg == 12'(TIMEOUT_STEPS - 1));

    // three minutes at full speed out of range
    always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
        tmo_cnt_reg <= 12'h000;
      end else if (!watching || tmo_hit[t]) begin
        tmo_cnt_reg <= 12'h000;
      end else if (step_en) begin
        tmo_cnt_reg <= tmo_cnt_reg + 12'h001;
      end
    end

    AST_TIMEOUT_SET: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      tmo_hit[t] |=> status_reg[fan_alarm_pkg::BIT_TEMP_A + t]) else $error("Timeout lost");
  end

  // Event sources and write-one-to-clear
  always_comb begin
    status_set = 7'h00;
    status_set[fan_alarm_pkg::BIT_FIFTH_TACH]   = FIFTH_TACH_LIMIT_FLAG;
    status_set[fan_alarm_pkg::BIT_FOURTH_TACH]  = FOURTH_TACH_LIMIT_FLAG;
    status_set[fan_alarm_pkg::BIT_BATTERY_RAIL] = BATTERY_RAIL_FLAG;
    status_set[fan_alarm_pkg::BIT_STANDBY_RAIL] = STANDBY_RAIL_FLAG;
    status_set[2:0] = tmo_hit;
    status_clr = (bus_wr && idx == fan_alarm_pkg::IDX_ALARM_STATUS) ?
                 (PWDATA[6:0] & fan_alarm_pkg::LIVE_BITS) : 7'h00;
    // Set wins over a clear in the same cycle
    status_next = (status_reg & ~status_clr) | status_set;
  end

  // Sticky status
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      status_reg <= fan_alarm_pkg::RST_STATUS[6:0];
    end else begin
      status_reg <= status_next;
    end
  end

  // Interrupt outputs
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      SYSTEM_MGMT_IRQ_OUT_N <= 1'b1;
      IRQ_OUT               <= 1'b0;
    end else begin
      SYSTEM_MGMT_IRQ_OUT_N <= ~|(status_reg & ~smi_mask_reg);
      IRQ_OUT               <= |(status_reg & ~irq_mask_reg);
    end
  end

  AST_FAN_SET: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    FIFTH_TACH_LIMIT_FLAG |=> status_reg[fan_alarm_pkg::BIT_FIFTH_TACH])
    else $error("Fifth fan flag lost");
  AST_RAIL_SET: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    STANDBY_RAIL_FLAG |=> status_reg[fan_alarm_pkg::BIT_STANDBY_RAIL])
    else $error("Standby flag lost");
  AST_STATUS_STICKY: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (status_reg != 7'h00) && !bus_wr |=> ((status_reg & $past(status_reg)) == $past(status_reg)))
    else $error("Status bit dropped");
  AST_SMI_MASK: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ((status_reg & ~smi_mask_reg) == 7'h00) |=> SYSTEM_MGMT_IRQ_OUT_N)
    else $error("Masked SMI asserted");
  AST_IRQ_MASK: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ((status_reg & ~irq_mask_reg) != 7'h00) |=> IRQ_OUT) else $error("Unmasked IRQ missing");
  AST_READY_PULSE: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    PREADY |=> !PREADY) else $error("PREADY held");

endmodule

// ==== fan_load_model.sv ====
`timescale 1ns/100ps
module fan_load_model (
  // Clock and control
  input  wire logic       clk,
  input  wire logic       clr,
  // Fan drive lines
  input  wire logic [1:0] pwm,
  // High-time counts
  output int              high_a,
  output int              high_b
);
  // Counts cycles each drive line sits high; an unknown counts as low
  always_ff @(posedge clk) begin
    if (clr) begin
      high_a <= 0;
      high_b <= 0;
    end else begin
      high_a <= high_a + int'(pwm[0] === 1'b1);
      high_b <= high_b + int'(pwm[1] === 1'b1);
    end
  end
endmodule

// ==== fan_pwm_alarm_tb.sv ====
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("wrong value at %0t: %0h not %0h", $time, got, exp); \
  end \
end
module fan_pwm_alarm_tb;
  // Bench signals
  logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr, irq, smi_n, clr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  ev;
  logic [1:0]  pwm;
  logic [7:0]  m;
  int          fail_count, n_compared, cyc, ha, hb;
  fan_alarm_pkg::temp_watch_t watch [3];
  fan_alarm_pkg::auto_duty_t  autod [2];
  localparam int         F = fan_alarm_pkg::FAST_CYC;
  localparam logic [7:0] RST_TAB [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'hFF, 8'hFF};

  fan_pwm_alarm #(.STEP_CYCLES(10), .TIMEOUT_STEPS(4)) uut (
    .SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FOURTH_TACH_LIMIT_FLAG(ev[2]), .FIFTH_TACH_LIMIT_FLAG(ev[3]),
    .BATTERY_RAIL_FLAG(ev[1]), .STANDBY_RAIL_FLAG(ev[0]), .TEMP_WATCH(watch),
    .AUTO_DUTY(autod), .PWM_OUT(pwm), .SYSTEM_MGMT_IRQ_OUT_N(smi_n), .IRQ_OUT(irq)
  );

  fan_load_model load (.clk(sys_clk), .clr(clr), .pwm(pwm), .high_a(ha), .high_b(hb));

  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      final_report();
    end
  end

  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; waits for pready, the cycle guard ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK({err, rd}, {25'h0, e})
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic set_watch(input logic o, input logic f);
    @(posedge sys_clk);
    for (int j = 0; j < 3; j++) watch[j] <= '{o, f};
  endtask

  // Clears the load counts, then counts for n cycles
  task automatic measure(input int n);
    @(posedge sys_clk) clr <= 1'b1;
    @(posedge sys_clk) clr <= 1'b0;
    hold(n);
  endtask

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, ev, clr} = '0;
    watch = '{default: '0};
    autod = '{default: '0};
    fail_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    hold(1);
    `CHK({pwm, smi_n, irq}, 4'b1110)
    for (int i = 0; i < 7; i++) rd_chk(ba(8'h9B + 8'(i)), RST_TAB[i]);
    apb(1'b1, ba(fan_alarm_pkg::IDX_SMI_MASK), 8'hFF);
    rd_chk(ba(fan_alarm_pkg::IDX_SMI_MASK), 8'h7F);
    apb(1'b1, ba(fan_alarm_pkg::IDX_SMI_MASK), 8'h00);
    // each event, masked per output, then cleared
    for (int i = 0; i < 4; i++) begin
      m = 8'h08 << i;
      @(posedge sys_clk) ev <= 4'b0001 << i;
      @(posedge sys_clk) ev <= 4'h0;
      hold(3);
      `CHK({smi_n, irq}, 2'b01)
      rd_chk(ba(fan_alarm_pkg::IDX_ALARM_STATUS), m);
      apb(1'b1, ba(fan_alarm_pkg::IDX_IRQ_MASK), m);
      hold(2);
      `CHK({smi_n, irq}, 2'b00)
      apb(1'b1, ba(fan_alarm_pkg::IDX_SMI_MASK), m);
      hold(2);
      `CHK({smi_n, irq}, 2'b10)
      apb(1'b1, ba(fan_alarm_pkg::IDX_ALARM_STATUS), m);
      rd_chk(ba(fan_alarm_pkg::IDX_ALARM_STATUS), 8'h00);
      apb(1'b1, ba(fan_alarm_pkg::IDX_IRQ_MASK), 8'h00);
      apb(1'b1, ba(fan_alarm_pkg::IDX_SMI_MASK), 8'h00);
    end
    // target timeouts: no fan, short spell, full spell
    set_watch(1'b1, 1'b0);
    hold(60);
    rd_chk(ba(fan_alarm_pkg::IDX_ALARM_STATUS), 8'h00);
    set_watch(1'b1, 1'b1);
    hold(20);
    set_watch(1'b0, 1'b0);
    rd_chk(ba(fan_alarm_pkg::IDX_ALARM_STATUS), 8'h00);
    set_watch(1'b1, 1'b1);
    hold(60);
    set_watch(1'b0, 1'b0);
    rd_chk(ba(fan_alarm_pkg::IDX_ALARM_STATUS), 8'h07);
    `CHK({smi_n, irq}, 2'b01)
    apb(1'b1, ba(fan_alarm_pkg::IDX_ALARM_STATUS), 8'h07);
    @(posedge sys_clk) autod <= '{'{1'b1, 8'h33}, '{1'b1, 8'h5A}};
    rd_chk(ba(fan_alarm_pkg::IDX_PWM_A_DUTY), 8'h33);
    rd_chk(ba(fan_alarm_pkg::IDX_PWM_B_DUTY), 8'h5A);
    @(posedge sys_clk) autod <= '{default: '0};
    rd_chk(ba(fan_alarm_pkg::IDX_PWM_A_DUTY), 8'hFF);
    // constant levels at the duty extremes
    apb(1'b1, ba(fan_alarm_pkg::IDX_PWM_B_DUTY), 8'h00);
    measure(1000);
    `CHK(ha, 1000)
    `CHK(hb, 0)
    // divider 1 and 2, high share over whole periods
    apb(1'b1, ba(fan_alarm_pkg::IDX_PWM_A_DIV), 8'h00);
    apb(1'b1, ba(fan_alarm_pkg::IDX_PWM_A_DUTY), 8'h40);
    apb(1'b1, ba(fan_alarm_pkg::IDX_PWM_B_DUTY), 8'h80);
    hold(512 * F);
    measure(512 * F);
    `CHK(ha, 2 * 64 * F)
    `CHK(hb, 128 * 2 * F)
    // Unmapped and misaligned places are refused
    apb(1'b0, 12'h288, 8'h00);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, 12'h27A, 8'h55);
    rd_chk(ba(fan_alarm_pkg::IDX_PWM_A_DIV), 8'h00);
    // Fresh reset aligns the dividers, then the slow source steps once per 1000 cycles
    @(posedge sys_clk) nrst <= 1'b0;
    @(posedge sys_clk) nrst <= 1'b1;
    apb(1'b1, ba(fan_alarm_pkg::IDX_PWM_B_DIV), 8'h80);
    apb(1'b1, ba(fan_alarm_pkg::IDX_PWM_B_DUTY), 8'h02);
    measure(3000);
    `CHK(hb > 1900 && hb <= 2000, 1'b1)
    final_report();
  end
endmodule
